// [pin_sync3.sv]
`timescale 1ns/1ps
// =====================================================================
// Three-stage pin synchroniser with agreement filter.
// =====================================================================
module pin_sync3 #(
   parameter int unsigned   W       = 1,
   parameter logic [W-1:0]  RST_VAL = '0
) (
   // Clock and synchronised reset.
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   // Asynchronous pins and their filtered levels.
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o
);

   logic [W-1:0] s1_q;     // First stage, read only by the second.
   logic [W-1:0] s2_q;     // Second stage.
   logic [W-1:0] s3_q;     // Third stage.
   logic [W-1:0] level_q;  // Accepted level.
   logic [W-1:0] agree;    // Second and third stage agree.

   assign agree   = ~(s2_q ^ s3_q);
   assign level_o = level_q;

   // Shift chain; the first stage may go metastable, so nothing but the
   // second stage looks at it.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change is accepted once two clean stages agree on it.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_q <= RST_VAL;
      end else begin
         level_q <= (agree & s3_q) | (~agree & level_q); // R14
      end
   end

   // The level only moves to a value both late stages held.
   a_sync_agree: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      level_q != $past(level_q) |-> level_q == ($past(agree & s3_q)
         | $past(~agree & level_q))) // R14
      else $error("synchroniser level moved without agreement");

endmodule // pin_sync3

// [regulator_ctrl_pkg.sv]
// =====================================================================
// Shared constants for the regulator mode and low-voltage controller.
// =====================================================================
package regulator_ctrl_pkg;

   // Register bus geometry.
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Offset of the single control register.
   localparam logic [ADDR_W-1:0] REGULATOR_CONTROL_ADDR = 8'h00;

   // Field positions inside the control register.
   localparam int unsigned CHANGE_FLAG_BIT = 0;
   localparam int unsigned IRQ_ENABLE_BIT  = 1;
   localparam int unsigned STATUS_BIT      = 2;

   // Reset values of the control state.
   localparam logic CHANGE_FLAG_RST = 1'h0;
   localparam logic IRQ_ENABLE_RST  = 1'h0;
   localparam logic STATUS_RST      = 1'h0;
   localparam logic POR_RST         = 1'h1;
   localparam logic DRIVE_EN_RST    = 1'h0;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   // Order of the asynchronous inputs inside the synchroniser vector.
   localparam int unsigned IN_W        = 5;
   localparam int unsigned IN_SUPPLY   = 0;
   localparam int unsigned IN_STOP     = 1;
   localparam int unsigned IN_ENABLE   = 2;
   localparam int unsigned IN_CORE_LOW = 3;
   localparam int unsigned IN_LVR      = 4;

   // Safe levels assumed before the pins have been sampled: regulator
   // enabled, core supply taken as low so power-on reset stays asserted.
   localparam logic [IN_W-1:0] IN_RST = 5'h0C;

   // Operating modes of the regulator.
   typedef enum logic [1:0] {
      MODE_FULL,
      MODE_REDUCED,
      MODE_SHUTDOWN
   } mode_e;

endpackage : regulator_ctrl_pkg

// [regulator_far_side_model.sv]
`timescale 1ns/1ps
// =====================================================================
// Far side: stop control, enable pin, supply comparators and interrupt controller.
// =====================================================================
module regulator_far_side_model (
   // Clock.
   input  wire logic ref_clk_i,
   // Requests coming back from the controller.
   input  wire logic low_voltage_interrupt_i,
   input  wire logic power_on_reset_i,
   // Levels the bench asks the far side to present.
   input  wire logic supply_req_i,
   input  wire logic core_req_i,
   input  wire logic lvr_req_i,
   input  wire logic stop_req_i,
   input  wire logic enable_req_i,
   // Comparator levels and control pins.
   output logic      supply_low_o,
   output logic      core_supply_low_o,
   output logic      core_lvr_low_o,
   output logic      mcu_stop_o,
   output logic      regulator_enable_o
);
   // Interrupt controller view: rising requests seen so far.
   int   irq_edges = 0;
   logic irq_last  = 1'b0;

   // Count each new request once, as a vectoring controller would.
   always @(posedge ref_clk_i) begin
      irq_last <= low_voltage_interrupt_i;
      if (low_voltage_interrupt_i && !irq_last) begin
         irq_edges <= irq_edges + 1;
      end
   end

   // Pins follow the requested levels just after each rising edge.
   always @(posedge ref_clk_i) begin
      supply_low_o      <= supply_req_i;
      core_supply_low_o <= core_req_i;
      core_lvr_low_o    <= lvr_req_i;
      mcu_stop_o        <= stop_req_i;
   end

   // The enable pin only moves while the core is held in reset.
   always @(posedge ref_clk_i) begin
      if (power_on_reset_i) begin
         regulator_enable_o <= enable_req_i;
      end
   end
endmodule // regulator_far_side_model

// [regulator_mode_lowvolt_ctrl.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// =====================================================================
// Regulator mode and low-voltage control: top level.
// =====================================================================
// Notes on behaviour
// [R1] Status bit two is read-only mirror.
// [R2] Status reads one only when low in full mode.
// [R3] Enable bit one raises request while flag set.
// [R4] Flag bit zero sets on every status change; the forced zero on leaving full mode does not set it.
// [R5] Writing one clears flag; zero ignored.
// [R6] Entering reduced power keeps the flag.
// [R7] Not stopped means full mode, all checks on.
// [R8] Stopped means reduced mode, only power-on reset.
// [R9] Enable low forces shutdown; else stop decides.
// [R10] Shutdown floats both outputs, only power-on reset.
// [R11] System never toggles enable while powered.
// [R12] Power-on reset holds until core supply good.
// [R13] Interrupt only in full mode with enable.
// [R14] Comparator passes a synchroniser before use.
module regulator_mode_lowvolt_ctrl
   import regulator_ctrl_pkg::*;
(
   // Clock and reset.
   input  wire logic                                 ref_clk_i,
   input  wire logic                                 resetn_i,
   // Register port.
   input  wire logic [regulator_ctrl_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [regulator_ctrl_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                                 wr_i,
   input  wire logic                                 rd_i,
   output logic      [regulator_ctrl_pkg::DATA_W-1:0] rdata_o,
   // Analog comparator results and control pins, all asynchronous.
   input  wire logic                                 supply_low_i,
   input  wire logic                                 core_supply_low_i,
   input  wire logic                                 core_lvr_low_i,
   input  wire logic                                 mcu_stop_i,
   input  wire logic                     regulator_enable_input_i,
   // Reset and interrupt requests.
   output logic                                 low_voltage_interrupt_o,
   output logic                                 power_on_reset_o,
   output logic                                 undervoltage_reset_o,
   // Regulator drive enables, low means high impedance.
   output logic                                 primary_drive_en_o,
   output logic                                 secondary_drive_en_o,
   // Mode indication.
   output logic                                 full_performance_state_o,
   output logic                                 reduced_power_state_o,
   output logic                                 shutdown_state_o
);

   // ==================================================================
   // Reset release
   // ==================================================================

   logic rst_meta_q;  // First release stage.
   logic rst_n;       // Synchronised reset used by the whole block.

   // Assertion is immediate; release waits two edges so every flop in
   // the block leaves reset on the same clock.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'h0;
         rst_n      <= 1'h0;
      end else begin
         rst_meta_q <= 1'h1;
         rst_n      <= rst_meta_q;
      end
   end

   // ==================================================================
   // Input synchronisation and mode
   // ==================================================================

   logic [IN_W-1:0] pins_async;  // Raw asynchronous inputs.
   logic [IN_W-1:0] pins_lvl;    // Filtered levels.
   mode_e           mode;        // Current operating mode.
   logic            det_on;      // Detector and UNDERVOLTAGE_RESET enabled.

   assign pins_async[IN_SUPPLY]   = supply_low_i;
   assign pins_async[IN_STOP]     = mcu_stop_i;
   assign pins_async[IN_ENABLE]   = regulator_enable_input_i;
   assign pins_async[IN_CORE_LOW] = core_supply_low_i;
   assign pins_async[IN_LVR]      = core_lvr_low_i;

   // Every pin, the comparator among them, is filtered before use.
   pin_sync3 #(
      .W       (IN_W),
      .RST_VAL (IN_RST)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n),
      .async_i   (pins_async), // R14
      .level_o   (pins_lvl)
   );

   // The enable pin is followed as it is; switching it while powered is
   // unsupported, so no glitch-free hand-over is attempted.
   regulator_mode_sel u_mode (
      .ref_clk_i                (ref_clk_i),
      .rst_n_i                  (rst_n),
      .mcu_stop_i               (pins_lvl[IN_STOP]),
      .regulator_enable_input_i (pins_lvl[IN_ENABLE]), // R11
      .mode_o                   (mode)
   );

   // Only full performance powers the detector and the UNDERVOLTAGE_RESET comparator.
   assign det_on = (mode == MODE_FULL); // R7 R8 R10

   // ==================================================================
   // Control register state
   // ==================================================================

   logic status_q;   // Low-voltage status.
   logic status_d;   // Next status.
   logic ie_q;       // Interrupt enable.
   logic flag_q;     // Sticky change flag.
   logic hit;        // Address selects the control register.
   logic wr_hit;     // Write to the control register.
   logic clr_req;    // Software asks to clear the flag.
   logic status_chg; // Status is about to change.

   assign hit     = (addr_i == REGULATOR_CONTROL_ADDR);
   assign wr_hit  = wr_i && hit;
   assign clr_req = wr_hit && wdata_i[CHANGE_FLAG_BIT];

   // Status mirrors the comparator in full mode and reads zero in the
   // other modes; the write data never reach it.
   assign status_d   = det_on && pins_lvl[IN_SUPPLY]; // R1 R2
   assign status_chg = det_on && (status_d != status_q);

   // Status register.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= STATUS_RST;
      end else begin
         status_q <= status_d; // R1 R2
      end
   end

   // Interrupt enable, the one bit software steers.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ie_q <= IRQ_ENABLE_RST;
      end else if (wr_hit) begin
         ie_q <= wdata_i[IRQ_ENABLE_BIT];
      end
   end

   // Change flag. A change in the same cycle as a clear wins, so no
   // event is lost. Changes are only counted while the detector runs;
   // the forced zero on leaving full mode is not an event, but a return to
   // full mode with the supply still low sets the flag.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= CHANGE_FLAG_RST;
      end else if (status_chg) begin
         flag_q <= 1'h1;  // R4
      end else if (clr_req) begin
         flag_q <= 1'h0;  // R5
      end
   end // R6

   // ==================================================================
   // Read port
   // ==================================================================

   logic [DATA_W-1:0] rd_word;  // Current register image.
   logic [DATA_W-1:0] rdata_q;  // Read data, valid one cycle.

   // Unused bits read as zero.
   always_comb begin
      rd_word                  = READ_IDLE;
      rd_word[STATUS_BIT]      = status_q;
      rd_word[IRQ_ENABLE_BIT]  = ie_q;
      rd_word[CHANGE_FLAG_BIT] = flag_q;
   end

   // Read data stand only in the cycle after the strobe; an unmapped
   // address answers zero.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= READ_IDLE;
      end else if (rd_i && hit) begin
         rdata_q <= rd_word;
      end else begin
         rdata_q <= READ_IDLE;
      end
   end

   assign rdata_o = rdata_q;

   // ==================================================================
   // Reset, interrupt and drive outputs
   // ==================================================================

   logic irq_q;     // Interrupt request.
   logic por_q;     // Power-on reset.
   logic lvr_q;     // Low-voltage reset.
   logic drive_q;   // Regulator outputs driven.
   logic full_q;    // Full-performance indication.
   logic red_q;     // Reduced-power indication.
   logic shut_q;    // Shutdown indication.

   // The request is a level that follows the flag; it drops as soon as
   // software clears the flag or the mode leaves full performance.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'h0;
      end else begin
         irq_q <= flag_q && ie_q && det_on; // R3 R13
      end
   end

   // Power-on reset runs in every mode and starts asserted.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         por_q <= POR_RST;
      end else begin
         por_q <= pins_lvl[IN_CORE_LOW]; // R12
      end
   end

   // Low-voltage reset is gated off outside full performance.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lvr_q <= 1'h0;
      end else begin
         lvr_q <= det_on && pins_lvl[IN_LVR]; // R7 R8 R10
      end
   end

   // Both regulator outputs float in shutdown, so an external supply
   // can take over; they stay off until the mode is known.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         drive_q <= DRIVE_EN_RST;
      end else begin
         drive_q <= (mode != MODE_SHUTDOWN); // R10
      end
   end

   // Mode indication flops.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         full_q <= 1'h0;
         red_q  <= 1'h0;
         shut_q <= 1'h0;
      end else begin
         full_q <= (mode == MODE_FULL);
         red_q  <= (mode == MODE_REDUCED);
         shut_q <= (mode == MODE_SHUTDOWN);
      end
   end

   assign low_voltage_interrupt_o  = irq_q;
   assign power_on_reset_o         = por_q;
   assign undervoltage_reset_o     = lvr_q;
   assign primary_drive_en_o       = drive_q;
   assign secondary_drive_en_o     = drive_q;
   assign full_performance_state_o = full_q;
   assign reduced_power_state_o    = red_q;
   assign shutdown_state_o         = shut_q;

   // ==================================================================
   // Checks
   // ==================================================================

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   a_status_mirror: assert property ( // R1
      wr_hit |=> status_q == $past(det_on && pins_lvl[IN_SUPPLY]))
      else $error("status bit took write data");

   a_status_mode: assert property ( // R2
      status_q |-> $past(mode == MODE_FULL) && $past(pins_lvl[IN_SUPPLY]))
      else $error("status set outside full mode or without low supply");

   a_irq_raise: assert property ( // R3
      flag_q && ie_q && det_on |=> low_voltage_interrupt_o)
      else $error("enabled pending flag raised no request");

   a_flag_on_change: assert property ( // R4
      status_q != $past(status_q) && $past(det_on) |-> flag_q)
      else $error("status change did not set flag");

   a_flag_clear: assert property ( // R5
      clr_req && !status_chg && flag_q |=> !flag_q ##1 1)
      else $error("write one did not clear flag");

   a_flag_zero_write: assert property ( // R5
      flag_q && !clr_req |=> flag_q)
      else $error("flag cleared without write one");

   a_flag_keep_rpm: assert property ( // R6
      flag_q && mode == MODE_FULL ##1 mode == MODE_REDUCED && !clr_req
      |=> flag_q)
      else $error("flag lost on entering reduced power");

   a_mode_full: assert property ( // R7
      !pins_lvl[IN_STOP] && pins_lvl[IN_ENABLE] |=> mode == MODE_FULL
      ##1 full_performance_state_o)
      else $error("not stopped but not in full mode");

   a_mode_reduced: assert property ( // R8
      pins_lvl[IN_STOP] && pins_lvl[IN_ENABLE] |=> mode == MODE_REDUCED
      ##1 !undervoltage_reset_o && !low_voltage_interrupt_o)
      else $error("stop did not give reduced mode with checks off");

   a_mode_shutdown: assert property ( // R9
      !pins_lvl[IN_ENABLE] |=> mode == MODE_SHUTDOWN)
      else $error("enable low did not give shutdown");

   a_hiz_shutdown: assert property ( // R10
      mode == MODE_SHUTDOWN |=> !primary_drive_en_o && !secondary_drive_en_o
      && !undervoltage_reset_o)
      else $error("outputs driven in shutdown");

   a_por_follow: assert property ( // R12
      pins_lvl[IN_CORE_LOW] |=> power_on_reset_o)
      else $error("power-on reset released with core supply low");

   a_irq_gate: assert property ( // R13
      low_voltage_interrupt_o |-> $past(det_on) && $past(ie_q))
      else $error("interrupt outside full mode or while disabled");

endmodule // regulator_mode_lowvolt_ctrl

// [regulator_mode_lowvolt_ctrl_tb.sv]
`timescale 1ns/1ps
`define chk(act, exp) begin \
   cmp_count++; \
   if ((act) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value at %0t ns: got %h want %h", $time, act, exp); \
   end \
end
// =====================================================================
// Self-checking bench for the regulator mode and low-voltage control.
// =====================================================================
module regulator_mode_lowvolt_ctrl_tb;
   logic       ref_clk_i = 1'b0;
   logic       resetn_i  = 1'b0;
   logic [7:0] addr_i    = 8'h00;
   logic [7:0] wdata_i   = 8'h00;
   logic       wr_i      = 1'b0;
   logic       rd_i      = 1'b0;
   logic [7:0] rdata_o;
   logic       supply_low, core_low, lvr_low, stop, enable;
   // Levels asked of the far side; it puts them on the pins.
   logic       supply_req = 1'b0, core_req = 1'b1, lvr_req = 1'b0;
   logic       stop_req = 1'b0, enable_req = 1'b1;
   logic       low_voltage_interrupt_o, power_on_reset_o;
   logic       undervoltage_reset_o;
   logic       primary_drive_en_o, secondary_drive_en_o;
   logic       full_performance_state_o, reduced_power_state_o;
   logic       shutdown_state_o;
   int         error_cnt = 0;
   int         cmp_count = 0;

   // 200 MHz clock.
   always #2.5 ref_clk_i = ~ref_clk_i;

   regulator_mode_lowvolt_ctrl i_regulator_mode_lowvolt_ctrl (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .supply_low_i(supply_low), .core_supply_low_i(core_low),
      .core_lvr_low_i(lvr_low), .mcu_stop_i(stop),
      .regulator_enable_input_i(enable),
      .low_voltage_interrupt_o(low_voltage_interrupt_o),
      .power_on_reset_o(power_on_reset_o),
      .undervoltage_reset_o(undervoltage_reset_o),
      .primary_drive_en_o(primary_drive_en_o),
      .secondary_drive_en_o(secondary_drive_en_o),
      .full_performance_state_o(full_performance_state_o),
      .reduced_power_state_o(reduced_power_state_o),
      .shutdown_state_o(shutdown_state_o));

   regulator_far_side_model i_model (
      .ref_clk_i(ref_clk_i),
      .low_voltage_interrupt_i(low_voltage_interrupt_o),
      .power_on_reset_i(power_on_reset_o),
      .supply_req_i(supply_req), .core_req_i(core_req),
      .lvr_req_i(lvr_req), .stop_req_i(stop_req),
      .enable_req_i(enable_req),
      .supply_low_o(supply_low), .core_supply_low_o(core_low),
      .core_lvr_low_o(lvr_low), .mcu_stop_o(stop),
      .regulator_enable_o(enable));

   // One-cycle write strobe on the register port.
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   // Read, compare the answer, then see it fall back to zero.
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      `chk(rdata_o, e)
      @(posedge ref_clk_i);
      #1;
      `chk(rdata_o, 8'h00)
   endtask

   // Model, synchroniser and output flops take seven edges; one spare.
   task automatic settle();
      repeat (8) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic test_reset();
      `chk(power_on_reset_o, 1'b1)
      @(posedge ref_clk_i) core_req <= 1'b0;
      settle();
      `chk(power_on_reset_o, 1'b0)
      `chk(full_performance_state_o, 1'b1)
      `chk(primary_drive_en_o & secondary_drive_en_o, 1'b1)
      expect_reg(8'h00, 8'h00);
      reg_wr(8'h10, 8'h02);
      expect_reg(8'h00, 8'h00);
      $display("test reset done");
   endtask

   task automatic test_status_flag();
      reg_wr(8'h00, 8'h06);
      expect_reg(8'h00, 8'h02);
      @(posedge ref_clk_i) supply_req <= 1'b1;
      settle();
      expect_reg(8'h00, 8'h07);
      `chk(low_voltage_interrupt_o, 1'b1)
      expect_reg(8'h10, 8'h00);
      reg_wr(8'h00, 8'h02);
      expect_reg(8'h00, 8'h07);
      reg_wr(8'h00, 8'h03);
      expect_reg(8'h00, 8'h06);
      `chk(low_voltage_interrupt_o, 1'b0)
      @(posedge ref_clk_i) supply_req <= 1'b0;
      settle();
      expect_reg(8'h00, 8'h03);
      `chk(low_voltage_interrupt_o, 1'b1)
      reg_wr(8'h00, 8'h03);
      expect_reg(8'h00, 8'h02);
      $display("test status flag done");
   endtask

   task automatic test_enable_gate();
      reg_wr(8'h00, 8'h00);
      @(posedge ref_clk_i) supply_req <= 1'b1;
      settle();
      `chk(low_voltage_interrupt_o, 1'b0)
      expect_reg(8'h00, 8'h05);
      reg_wr(8'h00, 8'h02);
      expect_reg(8'h00, 8'h07);
      `chk(low_voltage_interrupt_o, 1'b1)
      $display("test enable gate done");
   endtask

   // Flag pending across a stop period; detectors gated meanwhile.
   task automatic test_reduced();
      @(posedge ref_clk_i) lvr_req <= 1'b1;
      settle();
      `chk(undervoltage_reset_o, 1'b1)
      @(posedge ref_clk_i) stop_req <= 1'b1;
      settle();
      `chk(reduced_power_state_o, 1'b1)
      `chk(full_performance_state_o, 1'b0)
      `chk(undervoltage_reset_o, 1'b0)
      `chk(low_voltage_interrupt_o, 1'b0)
      expect_reg(8'h00, 8'h03);
      @(posedge ref_clk_i) stop_req <= 1'b0;
      settle();
      `chk(full_performance_state_o, 1'b1)
      `chk(undervoltage_reset_o, 1'b1)
      `chk(low_voltage_interrupt_o, 1'b1)
      expect_reg(8'h00, 8'h07);
      reg_wr(8'h00, 8'h03);
      expect_reg(8'h00, 8'h06);
      `chk(i_model.irq_edges, 4)
      $display("test reduced done");
   endtask

   // Enable only moves while the core is held by power-on reset.
   task automatic test_shutdown();
      @(posedge ref_clk_i) core_req <= 1'b1;
      settle();
      `chk(power_on_reset_o, 1'b1)
      @(posedge ref_clk_i) enable_req <= 1'b0;
      settle();
      `chk(shutdown_state_o, 1'b1)
      `chk(full_performance_state_o, 1'b0)
      `chk(primary_drive_en_o, 1'b0)
      `chk(secondary_drive_en_o, 1'b0)
      `chk(undervoltage_reset_o, 1'b0)
      `chk(power_on_reset_o, 1'b1)
      expect_reg(8'h00, 8'h02);
      @(posedge ref_clk_i) supply_req <= 1'b0;
      @(posedge ref_clk_i) enable_req <= 1'b1;
      @(posedge ref_clk_i) core_req <= 1'b0;
      settle();
      `chk(full_performance_state_o, 1'b1)
      `chk(power_on_reset_o, 1'b0)
      $display("test shutdown done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence: reset, then every scenario in turn.
   initial begin
      repeat (10) @(posedge ref_clk_i);
      `chk(power_on_reset_o, 1'b1)
      resetn_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      #1;
      test_reset();
      test_status_flag();
      test_enable_gate();
      test_reduced();
      test_shutdown();
      tally_and_finish();
   end

   // The scenarios need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      error_cnt++;
      $display("wrong value at %0t ns: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // regulator_mode_lowvolt_ctrl_tb

// [regulator_mode_sel.sv]
`timescale 1ns/1ps
// =====================================================================
// Operating mode selection from stop state and regulator enable.
// =====================================================================
module regulator_mode_sel
   import regulator_ctrl_pkg::*;
(
   // Clock and synchronised reset.
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Synchronised controls.
   input  wire logic mcu_stop_i,
   input  wire logic regulator_enable_input_i,
   // Selected mode.
   output regulator_ctrl_pkg::mode_e mode_o
);

   mode_e mode_q;  // Registered mode.
   mode_e mode_d;  // Next mode.

   assign mode_o = mode_q;

   // Enable low wins over everything; otherwise stop picks the mode.
   always_comb begin
      if (!regulator_enable_input_i) begin
         mode_d = MODE_SHUTDOWN; // R9
      end else if (mcu_stop_i) begin
         mode_d = MODE_REDUCED;  // R8
      end else begin
         mode_d = MODE_FULL;     // R7
      end
   end

   // Mode register; reset starts in full performance.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= MODE_FULL;
      end else begin
         mode_q <= mode_d;
      end
   end

endmodule // regulator_mode_sel
